// ### core/mcrc_pkg.sv
// Purpose: Constants and types for the module clock and reset controller
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Functional notes below
`default_nettype none
package mcrc_pkg;
    localparam int NUM_MOD = 35;
    localparam int DSP_MOD = 33;
    localparam logic [5:0] LAST_MOD = 6'h22;
    // Register map, byte addresses
    localparam logic [11:0] PLL_CTRL_ADR = 12'h100;
    localparam logic [11:0] CMD_ADR = 12'h120;
    localparam logic [11:0] TSTAT_ADR = 12'h128;
    localparam logic [11:0] STAT_BASE = 12'h800;
    localparam logic [11:0] CTL_BASE = 12'hA00;
    localparam logic [11:0] BANK_SPAN = 12'h08C;
    // module_control fields
    localparam int NEXT_LSB = 0;
    localparam int LOC_RST_BIT = 8;
    localparam int RST_IE_BIT = 9;
    localparam int STATE_IE_BIT = 10;
    // module_status fields
    localparam int LOC_RST_DONE_BIT = 9;
    localparam int MOD_RST_OFF_BIT = 10;
    localparam int RSV_ONE_BIT = 11;
    localparam int CLK_ON_BIT = 12;
    localparam int EMU_RST_ALT_BIT = 16;
    localparam int EMU_ST_ALT_BIT = 17;
    // pll control and command fields
    localparam int BYPASS_BIT = 0;
    localparam int PWRDN_BIT = 1;
    localparam int MULT_LSB = 8;
    localparam int DIV_LSB = 16;
    localparam int GO_BIT = 0;
    // State codes
    localparam logic [5:0] ST_RST_DIS = 6'h00;
    localparam logic [5:0] ST_SYNC_RST = 6'h01;
    localparam logic [5:0] ST_CLK_DIS = 6'h02;
    localparam logic [5:0] ST_CLK_EN = 6'h03;
    localparam logic [5:0] ST_TRANS = 6'h04;
    localparam logic [2:0] NEXT_MAX = 3'h3;
    // Reset values
    localparam logic [2:0] NEXT_RST = 3'h0;
    localparam logic [2:0] DSP_NEXT_RST = 3'h3;
    localparam logic [4:0] MULT_RST = 5'h0E;
    localparam logic [4:0] DIV_RST = 5'h00;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } mcrc_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } mcrc_wb_rsp_type;

    typedef enum logic [1:0] {
        S_IDLE, S_SCAN, S_DRAIN, S_APPLY
    } mcrc_fsm_type;
endpackage
`default_nettype wire

// ### core/mcrc_top.sv
// Purpose: Per-module clock enable and reset sequencer with PLL controls
// Assumes: Bus-busy and emulation inputs come from logic on clk
// Notes: Clock gating cells outside use mod_clk_en_q as their enable
`default_nettype none
module mcrc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire mcrc_pkg::mcrc_wb_req_type wb_req,
    output var mcrc_pkg::mcrc_wb_rsp_type wb_rsp,
    input wire logic [34:0] bus_busy,
    input wire logic emu_state_alt,
    input wire logic emu_reset_alt,
    output logic [34:0] mod_clk_en_q,
    output logic [34:0] mod_rst_n_q,
    output logic local_rst_n_q,
    output logic emu_irq_q,
    output logic pll_bypass_q,
    output logic pll_pwrdn_q,
    output logic [4:0] pll_mult_q,
    output logic [4:0] sys_div_q
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic in_bank(input logic [11:0] a,
                                     input logic [11:0] base);
        in_bank = (a >= base) && (a < base + mcrc_pkg::BANK_SPAN)
                  && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [5:0] bank_idx(input logic [11:0] a,
                                            input logic [11:0] base);
        logic [11:0] off;
        off = a - base;
        bank_idx = off[7:2];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic clk_on(input logic [5:0] code);
        clk_on = (code == mcrc_pkg::ST_SYNC_RST)
                 || (code == mcrc_pkg::ST_CLK_EN);
    endfunction

    function automatic logic rst_off(input logic [5:0] code);
        rst_off = (code == mcrc_pkg::ST_CLK_DIS)
                  || (code == mcrc_pkg::ST_CLK_EN);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic ack_q;
    logic [31:0] rdat_q;
    logic [2:0] next_q [0:34];
    logic [34:0] loc_rst_q;
    logic [34:0] ie_rst_q;
    logic [34:0] ie_ihb_q;
    logic [5:0] state_q [0:34];
    logic pending_q;
    logic [5:0] idx_q;
    mcrc_pkg::mcrc_fsm_type fsm_q;
    logic [31:0] pll_ctrl_q;
    logic emu_st_q;
    logic emu_rs_q;

    wire logic acc = wb_req.cyc & wb_req.stb & ~ack_q;
    wire logic wr = acc & wb_req.we;
    wire logic [11:0] adr = wb_req.adr[11:0];
    wire logic adr_hi_zero = (wb_req.adr[31:12] == 20'h00000);
    wire logic ctl_hit = adr_hi_zero & in_bank(adr, mcrc_pkg::CTL_BASE);
    wire logic stat_hit = adr_hi_zero & in_bank(adr, mcrc_pkg::STAT_BASE);
    wire logic pll_hit = adr_hi_zero & (adr == mcrc_pkg::PLL_CTRL_ADR);
    wire logic cmd_hit = adr_hi_zero & (adr == mcrc_pkg::CMD_ADR);
    wire logic tst_hit = adr_hi_zero & (adr == mcrc_pkg::TSTAT_ADR);
    wire logic [5:0] ctl_idx = bank_idx(adr, mcrc_pkg::CTL_BASE);
    wire logic [5:0] stat_idx = bank_idx(adr, mcrc_pkg::STAT_BASE);

    wire logic [31:0] ctl_word = {21'h000000,
        ie_ihb_q[ctl_idx], ie_rst_q[ctl_idx], loc_rst_q[ctl_idx],
        5'h00, next_q[ctl_idx]};
    wire logic [31:0] ctl_wdata = merge(ctl_word, wb_req.dat, wb_req.sel);
    wire logic [31:0] cmd_wdata = merge(32'h00000000, wb_req.dat,
                                        wb_req.sel);
    wire logic go_req = wr & cmd_hit & cmd_wdata[mcrc_pkg::GO_BIT];
    wire logic go_take = go_req & ~pending_q;

    // Emulation flags exist only for the DSP module
    wire logic is_dsp_rd = (stat_idx == 6'(mcrc_pkg::DSP_MOD));
    logic [31:0] stat_word;
    always_comb begin
        stat_word = 32'h00000000;
        stat_word[5:0] = state_q[stat_idx];
        stat_word[mcrc_pkg::LOC_RST_BIT] = loc_rst_q[stat_idx];
        stat_word[mcrc_pkg::LOC_RST_DONE_BIT] = loc_rst_q[stat_idx];
        stat_word[mcrc_pkg::MOD_RST_OFF_BIT] = mod_rst_n_q[stat_idx];
        stat_word[mcrc_pkg::RSV_ONE_BIT] = 1'b1;
        stat_word[mcrc_pkg::CLK_ON_BIT] = mod_clk_en_q[stat_idx];
        stat_word[mcrc_pkg::EMU_RST_ALT_BIT] = is_dsp_rd & emu_rs_q;
        stat_word[mcrc_pkg::EMU_ST_ALT_BIT] = is_dsp_rd & emu_st_q;
    end

    wire logic [31:0] rd_mux =
        ctl_hit ? ctl_word :
        stat_hit ? stat_word :
        pll_hit ? pll_ctrl_q :
        tst_hit ? {31'h00000000, pending_q} :
        32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state, unmapped reads give zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= acc;
            rdat_q <= rd_mux;
        end
    end
    assign wb_rsp.ack = ack_q;
    assign wb_rsp.dat = rdat_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < mcrc_pkg::NUM_MOD; i++) begin
                next_q[i] <= (i == mcrc_pkg::DSP_MOD) ?
                             mcrc_pkg::DSP_NEXT_RST : mcrc_pkg::NEXT_RST;
            end
            loc_rst_q <= '1;
            ie_rst_q <= '0;
            ie_ihb_q <= '0;
        end else if (wr && ctl_hit) begin
            // Reserved codes are stored but never acted on
            next_q[ctl_idx] <= ctl_wdata[2:0];
            loc_rst_q[ctl_idx] <= ctl_wdata[mcrc_pkg::LOC_RST_BIT];
            ie_rst_q[ctl_idx] <= ctl_wdata[mcrc_pkg::RST_IE_BIT];
            ie_ihb_q[ctl_idx] <= ctl_wdata[mcrc_pkg::STATE_IE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pll_ctrl_q <= {11'h000, mcrc_pkg::DIV_RST, 3'h0,
                           mcrc_pkg::MULT_RST, 8'h01};
        end else if (wr && pll_hit) begin
            pll_ctrl_q <= merge(pll_ctrl_q, wb_req.dat, wb_req.sel)
                          & 32'h001F1F03;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PLL side: bypass selects the reference clock for the dividers,
    // power-down is masked unless bypassed so dividers never starve
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pll_bypass_q <= 1'b1;
            pll_pwrdn_q <= 1'b0;
            pll_mult_q <= mcrc_pkg::MULT_RST;
            sys_div_q <= mcrc_pkg::DIV_RST;
        end else begin
            pll_bypass_q <= pll_ctrl_q[mcrc_pkg::BYPASS_BIT];
            pll_pwrdn_q <= pll_ctrl_q[mcrc_pkg::PWRDN_BIT]
                           & pll_ctrl_q[mcrc_pkg::BYPASS_BIT];
            pll_mult_q <= pll_ctrl_q[mcrc_pkg::MULT_LSB +: 5];
            sys_div_q <= pll_ctrl_q[mcrc_pkg::DIV_LSB +: 5];
        end
    end

    // Emulation events and their interrupt
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            emu_st_q <= 1'b0;
            emu_rs_q <= 1'b0;
            emu_irq_q <= 1'b0;
            local_rst_n_q <= 1'b1;
        end else begin
            emu_st_q <= emu_state_alt;
            emu_rs_q <= emu_reset_alt;
            emu_irq_q <= (emu_state_alt & ie_ihb_q[mcrc_pkg::DSP_MOD])
                         | (emu_reset_alt
                            & ie_rst_q[mcrc_pkg::DSP_MOD]);
            local_rst_n_q <= loc_rst_q[mcrc_pkg::DSP_MOD];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transition sequencer: walks all modules once per go
    wire logic [5:0] tgt = {3'h0, next_q[idx_q]};
    wire logic tgt_valid = (next_q[idx_q] <= mcrc_pkg::NEXT_MAX);
    wire logic needs_move = tgt_valid && (tgt != state_q[idx_q]);
    wire logic needs_drain = ~clk_on(tgt) & mod_clk_en_q[idx_q];
    wire logic last = (idx_q == mcrc_pkg::LAST_MOD);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fsm_q <= mcrc_pkg::S_IDLE;
            idx_q <= 6'h00;
            pending_q <= 1'b0;
            for (int i = 0; i < mcrc_pkg::NUM_MOD; i++) begin
                state_q[i] <= (i == mcrc_pkg::DSP_MOD) ?
                              mcrc_pkg::ST_CLK_EN : mcrc_pkg::ST_RST_DIS;
            end
            mod_clk_en_q <= 35'h000000000 | (35'h1 << mcrc_pkg::DSP_MOD);
            mod_rst_n_q <= 35'h000000000 | (35'h1 << mcrc_pkg::DSP_MOD);
        end else begin
            case (fsm_q)
                mcrc_pkg::S_IDLE: begin
                    if (go_take) begin
                        pending_q <= 1'b1;
                        idx_q <= 6'h00;
                        fsm_q <= mcrc_pkg::S_SCAN;
                    end
                end
                mcrc_pkg::S_SCAN: begin
                    if (needs_move) begin
                        state_q[idx_q] <= mcrc_pkg::ST_TRANS;
                        fsm_q <= needs_drain ? mcrc_pkg::S_DRAIN
                                             : mcrc_pkg::S_APPLY;
                    end else if (last) begin
                        pending_q <= 1'b0;
                        fsm_q <= mcrc_pkg::S_IDLE;
                    end else begin
                        idx_q <= idx_q + 6'h01;
                    end
                end
                mcrc_pkg::S_DRAIN: begin
                    // A hung access is waited out rather than cut off
                    if (!bus_busy[idx_q]) begin
                        fsm_q <= mcrc_pkg::S_APPLY;
                    end
                end
                mcrc_pkg::S_APPLY: begin
                    state_q[idx_q] <= tgt;
                    // Enable-style gating keeps module flops intact
                    mod_clk_en_q[idx_q] <= clk_on(tgt);
                    mod_rst_n_q[idx_q] <= rst_off(tgt);
                    if (last) begin
                        pending_q <= 1'b0;
                        fsm_q <= mcrc_pkg::S_IDLE;
                    end else begin
                        idx_q <= idx_q + 6'h01;
                        fsm_q <= mcrc_pkg::S_SCAN;
                    end
                end
                default: fsm_q <= mcrc_pkg::S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    ack_one_cycle_a: assert property (@(posedge clk) disable iff (sys_rst)
        ack_q |=> !ack_q)
        else $error("ack held more than one cycle");

    drain_hold_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (fsm_q == mcrc_pkg::S_DRAIN && bus_busy[idx_q])
        |=> fsm_q == mcrc_pkg::S_DRAIN && mod_clk_en_q[$past(idx_q)])
        else $error("clock gated while module bus busy");

    pending_done_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        $fell(pending_q) |-> $past(last) && fsm_q == mcrc_pkg::S_IDLE)
        else $error("pending cleared before walk finished");

    reserved_skip_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (fsm_q == mcrc_pkg::S_SCAN && !tgt_valid)
        |=> state_q[$past(idx_q)] == $past(state_q[idx_q]))
        else $error("reserved target changed module state");

    local_reset_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr && ctl_hit && ctl_idx == 6'(mcrc_pkg::DSP_MOD)
         && !ctl_wdata[mcrc_pkg::LOC_RST_BIT]) |=> ##1 !local_rst_n_q)
        else $error("local reset not asserted");

    state_irq_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (emu_state_alt && ie_ihb_q[mcrc_pkg::DSP_MOD]) |=> emu_irq_q)
        else $error("state override interrupt missing");

    reset_irq_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (emu_reset_alt && !ie_rst_q[mcrc_pkg::DSP_MOD]
         && !emu_state_alt) |=> !emu_irq_q)
        else $error("reset override interrupt not masked");

    pwrdn_bypass_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        pll_pwrdn_q |-> pll_bypass_q)
        else $error("pll powered down without bypass");

    bypass_follow_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr && pll_hit && wb_req.sel[0]
         && wb_req.dat[mcrc_pkg::BYPASS_BIT]) |=> ##1 pll_bypass_q)
        else $error("bypass write not applied");

    go_start_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        go_take |=> pending_q && fsm_q == mcrc_pkg::S_SCAN
                    && idx_q == 6'h00)
        else $error("go not taken");

endmodule
`default_nettype wire

// ### verif/mcrc_mod_model.sv
// Purpose: Behavioural model of the gated on-chip modules
// Assumes: Enables and resets come from the controller on clk
// Notes: Each module counts while clocked and out of reset
`default_nettype none
module mcrc_mod_model (
    input wire logic clk,
    input wire logic [34:0] clk_en,
    input wire logic [34:0] rst_n,
    input wire logic [34:0] busy_req,
    output logic [34:0] bus_busy,
    output logic [34:0][7:0] work_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////
    // A module without clock cannot keep an access open
    assign bus_busy = busy_req & clk_en;
    initial work_cnt = '0;
    always @(posedge clk) begin
        for (int i = 0; i < 35; i++) begin
            if (!rst_n[i]) begin
                work_cnt[i] <= 8'h00;
            end else if (clk_en[i]) begin
                work_cnt[i] <= work_cnt[i] + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/test_module_clock_reset_control.sv
// Purpose: Self-checking bench of the module clock and reset controller
// Assumes: Bus answers within a few cycles of a request
// Notes: Random module and PLL values from a fixed seed
`default_nettype none
module test_module_clock_reset_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    mcrc_pkg::mcrc_wb_req_type wb_req = '0;
    mcrc_pkg::mcrc_wb_rsp_type wb_rsp;
    logic [34:0] busy_req = '0;
    logic [34:0] bus_busy, clk_en, rst_n;
    logic emu_s = 1'b0;
    logic emu_r = 1'b0;
    logic loc_rst_n, irq, byp, pd;
    logic [4:0] mult, div;
    logic [34:0][7:0] cnt;
    logic [31:0] rd;
    logic [2:0] seq [5] = '{3'h3, 3'h5, 3'h2, 3'h1, 3'h0};
    int fail_count = 0;
    int n_compared = 0;
    int seed = 88;

    always #25 clk = ~clk;

    mcrc_top dut_u (.clk(clk), .sys_rst(sys_rst), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .bus_busy(bus_busy), .emu_state_alt(emu_s),
        .emu_reset_alt(emu_r), .mod_clk_en_q(clk_en), .mod_rst_n_q(rst_n),
        .local_rst_n_q(loc_rst_n), .emu_irq_q(irq), .pll_bypass_q(byp),
        .pll_pwrdn_q(pd), .pll_mult_q(mult), .sys_div_q(div));

    mcrc_mod_model model_u (.clk(clk), .clk_en(clk_en), .rst_n(rst_n),
        .busy_req(busy_req), .bus_busy(bus_busy), .work_cnt(cnt));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [11:0] adr(input logic [11:0] b, input int m);
        return b + 12'(4 * m);
    endfunction

    // Status word expected for a settled module with local reset off
    function automatic logic [31:0] exp_stat(input logic [2:0] s);
        logic c, r;
        c = (s == 3'h1) || (s == 3'h3);
        r = s >= 3'h2;
        return {19'h0, c, 1'b1, r, 2'b11, 5'h00, s};
    endfunction

    task automatic wb(input logic we, input logic [11:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {20'h0, a},
                    sel: 4'hF, dat: d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 20);
        if (wb_rsp.ack !== 1'b1) begin
            check("ack", 32'h1, 32'h0);
            print_verdict();
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        rd = 32'h1;
        while (rd[0] !== 1'b0 && n < 300) begin
            wb(1'b0, mcrc_pkg::TSTAT_ADR, 32'h0);
            n++;
        end
        if (rd[0] !== 1'b0) begin
            check("idle", 32'h0, rd);
            print_verdict();
        end
    endtask

    task automatic go(input int m, input logic [2:0] code);
        wait_idle();
        wb(1'b1, adr(mcrc_pkg::CTL_BASE, m),
           {23'h000000, 1'b1, 5'h00, code});
        wb(1'b1, mcrc_pkg::CMD_ADR, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        int m;
        logic [2:0] cur, code;
        logic [7:0] c0;
        logic [31:0] v;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check("clk_en", 32'h1, {31'h0, clk_en === 35'h200000000});
        check("rst_n", 32'h1, {31'h0, rst_n === 35'h200000000});
        wb(1'b0, adr(mcrc_pkg::CTL_BASE, 33), 32'h0);
        check("ctl33", 32'h00000103, rd);
        wb(1'b0, adr(mcrc_pkg::CTL_BASE, 0), 32'h0);
        check("ctl0", 32'h00000100, rd);
        wb(1'b0, mcrc_pkg::PLL_CTRL_ADR, 32'h0);
        check("pll", 32'h00000E01, rd);
        wb(1'b0, 12'h300, 32'h0);
        check("unmapped", 32'h0, rd);
        wb(1'b0, adr(mcrc_pkg::STAT_BASE, 33), 32'h0);
        check("stat33", exp_stat(3'h3), rd);
        // Every mix of enables, events and local reset on module 33
        for (int k = 0; k < 32; k++) begin
            wb(1'b1, adr(mcrc_pkg::CTL_BASE, 33), {21'h0, 3'(k >> 2), 8'h03});
            emu_s <= k[1];
            emu_r <= k[0];
            repeat (3) @(posedge clk);
            check("irq", {31'h0, (k[1] & k[4]) | (k[0] & k[3])},
                  {31'h0, irq});
            check("loc_rst", {31'h0, k[2]}, {31'h0, loc_rst_n});
            wb(1'b0, adr(mcrc_pkg::STAT_BASE, 33), 32'h0);
            check("emu_alt", {30'h0, k[1:0]}, {30'h0, rd[17:16]});
        end
        emu_s <= 1'b0;
        emu_r <= 1'b0;
        wb(1'b1, adr(mcrc_pkg::CTL_BASE, 33), 32'h00000103);
        // One random module walked through all states, reserved ones too
        m = ($random(seed) & 32'h7FFF) % 33;
        cur = 3'h0;
        for (int i = 0; i < 12; i++) begin
            code = (i < 5) ? seq[i] : 3'($random(seed));
            go(m, code);
            wait_idle();
            if (code <= 3'h3)
                cur = code;
            v = exp_stat(cur);
            wb(1'b0, adr(mcrc_pkg::STAT_BASE, m), 32'h0);
            check("state", v, rd);
            check("mod_clk", {31'h0, v[12]}, {31'h0, clk_en[m]});
            check("mod_rst", {31'h0, v[10]}, {31'h0, rst_n[m]});
        end
        wb(1'b1, adr(mcrc_pkg::STAT_BASE, m), 32'hFFFFFFFF);
        wb(1'b0, adr(mcrc_pkg::STAT_BASE, m), 32'h0);
        check("stat_ro", exp_stat(cur), rd);
        // Clock stop held off while the module bus is busy
        go(m, 3'h3);
        wait_idle();
        busy_req[m] <= 1'b1;
        go(m, 3'h2);
        repeat (60) @(posedge clk);
        check("held", 32'h1, {31'h0, clk_en[m]});
        wb(1'b0, mcrc_pkg::TSTAT_ADR, 32'h0);
        check("pending", 32'h1, rd);
        wb(1'b0, adr(mcrc_pkg::STAT_BASE, m), 32'h0);
        check("trans", {26'h0, mcrc_pkg::ST_TRANS}, {26'h0, rd[5:0]});
        busy_req[m] <= 1'b0;
        wait_idle();
        c0 = cnt[m];
        repeat (20) @(posedge clk);
        check("stopped", 32'h0, {31'h0, clk_en[m]});
        check("frozen", {24'h0, c0}, {24'h0, cnt[m]});
        go(m, 3'h3);
        wait_idle();
        check("resumed", 32'h1, {31'h0, cnt[m] !== c0});
        // PLL controls, first with power-down asked for without bypass
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            if (i == 0)
                v[1:0] = 2'b10;
            else if (i == 1)
                v[1:0] = 2'b11;
            v = v & 32'h001F1F03;
            wb(1'b1, mcrc_pkg::PLL_CTRL_ADR, v);
            @(posedge clk);
            check("bypass", {31'h0, v[0]}, {31'h0, byp});
            check("pwrdn", {31'h0, v[1] & v[0]}, {31'h0, pd});
            check("mult", {27'h0, v[12:8]}, {27'h0, mult});
            check("div", {27'h0, v[20:16]}, {27'h0, div});
        end
        print_verdict();
    end
endmodule
`default_nettype wire
